/* File: clt_pkg.sv */
`default_nettype none
package clt_pkg;
  // ----------------------------------------------------------------
  // clock and time bases
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int unsigned WD_TICK_S = 1;
  localparam int unsigned WD_TICK_CYCLES = CLK_HZ * WD_TICK_S;
  localparam int unsigned ST_TICK_S = 60;
  localparam int unsigned ST_TICK_CYCLES = CLK_HZ * ST_TICK_S;
  localparam int unsigned MIN_PER_H = 60;

  // ----------------------------------------------------------------
  // watchdog and safety timer periods
  // ----------------------------------------------------------------
  localparam logic [7:0] WD_P1_S = 8'h28;
  localparam logic [7:0] WD_P2_S = 8'h50;
  localparam logic [7:0] WD_P3_S = 8'ha0;
  localparam int unsigned ST_P0_H = 5;
  localparam int unsigned ST_P1_H = 8;
  localparam int unsigned ST_P2_H = 12;
  localparam int unsigned ST_P3_H = 20;

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IN_LIM_CTRL = 8'h03;
  localparam logic [7:0] ADDR_PRE_TERM = 8'h04;
  localparam logic [7:0] ADDR_CHG_CTRL_ONE = 8'h05;
  localparam logic [7:0] ADDR_WD_KICK = 8'h07;
  localparam logic [7:0] RST_IN_LIM_CTRL = 8'h39;
  localparam logic [7:0] RST_PRE_TERM = 8'h22;
  localparam logic [7:0] RST_CHG_CTRL_ONE = 8'h9d;
  localparam logic [4:0] IN_LIM_MAX_CODE = 5'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OPT_FORCE_BIT = 7;
  localparam int DET_FORCE_BIT = 6;
  localparam int OPT_EN_BIT = 5;
  localparam int IN_LIM_LSB = 0;
  localparam int PRE_LSB = 4;
  localparam int TERM_LSB = 0;
  localparam int TERM_EN_BIT = 7;
  localparam int IND_OFF_BIT = 6;
  localparam int WD_SEL_LSB = 4;
  localparam int TMR_EN_BIT = 3;
  localparam int TMR_SEL_LSB = 1;
  localparam int TMR_HALF_BIT = 0;
  localparam int KICK_BIT = 6;
endpackage
`default_nettype wire

/* File: clt_config_regs.sv */
// Notes on behaviour
// - optimizer force start gated, clears once started
// - force detect bit starts source detection
// - optimizer enable bit, enabled after reset
// - limit code 500mA+100mA/LSB, clamp at 1Ch
// - applied limit is minimum of register, pin, power select and, while enabled, optimizer result
// - precharge/termination 50mA+50mA/LSB, default 150mA
// - termination enable bit, default on
// - indicator disable bit turns status pin off
// - watchdog period off/40/80/160 seconds
// - safety timer enable at bit 3
// - fast charge timer 5/8/12/20 hours
// - half rate timer during regulation
// - control register at 05h resets 9Dh
// - watchdog kick restarts timer, self-clears
`timescale 1ns/1ps
`default_nettype none
module clt_config_regs #(
  parameter int unsigned WD_TICK_CYCLES = clt_pkg::WD_TICK_CYCLES,
  parameter int unsigned ST_TICK_CYCLES = clt_pkg::ST_TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  input wire logic reg_reset_i,
  input wire logic optimizer_started_i,
  input wire logic detect_done_i,
  input wire logic [4:0] optimizer_current_result_i,
  input wire logic [4:0] current_limit_pin_i,
  input wire logic [4:0] power_select_limit_i,
  input wire logic input_regulation_i,
  input wire logic thermal_regulation_i,
  input wire logic charge_active_i,
  output logic force_optimizer_start_o,
  output logic force_input_source_detect_o,
  output logic optimizer_enable_o,
  output logic [4:0] input_current_limit_o,
  output logic [3:0] precharge_current_o,
  output logic [3:0] termination_current_o,
  output logic termination_enable_o,
  output logic charge_indicator_disable_o,
  output logic watchdog_expired_o,
  output logic safety_timer_expired_o
);
  import clt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic opt_force;
    logic det_force;
    logic opt_en;
    logic [4:0] in_lim;
    logic [3:0] prechg;
    logic [3:0] term;
    logic term_en;
    logic ind_off;
    logic [1:0] wd_sel;
    logic tmr_en;
    logic [1:0] tmr_sel;
    logic tmr_half;
    logic kick;
    logic [31:0] wd_pre;
    logic [7:0] wd_sec;
    logic wd_exp;
    logic [31:0] st_pre;
    logic [10:0] st_min;
    logic st_phase;
    logic st_exp;
    logic [4:0] lim_eff;
    logic [7:0] rd_data;
  } clt_state_t;

  localparam clt_state_t RESET_STATE = '{
    det_force: RST_IN_LIM_CTRL[DET_FORCE_BIT],
    opt_en: RST_IN_LIM_CTRL[OPT_EN_BIT],
    in_lim: RST_IN_LIM_CTRL[IN_LIM_LSB +: 5],
    prechg: RST_PRE_TERM[PRE_LSB +: 4],
    term: RST_PRE_TERM[TERM_LSB +: 4],
    term_en: RST_CHG_CTRL_ONE[TERM_EN_BIT],
    ind_off: RST_CHG_CTRL_ONE[IND_OFF_BIT],
    wd_sel: RST_CHG_CTRL_ONE[WD_SEL_LSB +: 2],
    tmr_en: RST_CHG_CTRL_ONE[TMR_EN_BIT],
    tmr_sel: RST_CHG_CTRL_ONE[TMR_SEL_LSB +: 2],
    tmr_half: RST_CHG_CTRL_ONE[TMR_HALF_BIT],
    lim_eff: RST_IN_LIM_CTRL[IN_LIM_LSB +: 5],
    default: '0
  };

  clt_state_t st_r;
  clt_state_t st_nxt;
  logic wr_lim;
  logic wr_pt;
  logic wr_ctl;
  logic wr_kick;
  logic wd_fire;
  logic slowed;
  logic st_tick;
  logic [7:0] charger_control_one_now;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] wd_seconds(input logic [1:0] sel);
    if (sel == 2'b01) begin
      return WD_P1_S;
    end else if (sel == 2'b10) begin
      return WD_P2_S;
    end else if (sel == 2'b11) begin
      return WD_P3_S;
    end
    return 8'h00;
  endfunction

  function automatic logic [10:0] st_minutes(input logic [1:0] sel);
    case (sel)
      2'b00: return 11'(ST_P0_H * MIN_PER_H);
      2'b01: return 11'(ST_P1_H * MIN_PER_H);
      2'b10: return 11'(ST_P2_H * MIN_PER_H);
      default: return 11'(ST_P3_H * MIN_PER_H);
    endcase
  endfunction

  function automatic logic [4:0] min2(input logic [4:0] a,
                                      input logic [4:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic clt_state_t put_ctl(input clt_state_t s,
                                         input logic [7:0] b);
    clt_state_t r;
    r = s;
    r.term_en = b[TERM_EN_BIT];
    r.ind_off = b[IND_OFF_BIT];
    r.wd_sel = b[WD_SEL_LSB +: 2];
    r.tmr_en = b[TMR_EN_BIT];
    r.tmr_sel = b[TMR_SEL_LSB +: 2];
    r.tmr_half = b[TMR_HALF_BIT];
    return r;
  endfunction

  function automatic logic [7:0] rd_mux(input clt_state_t s,
                                        input logic [7:0] a);
    if (a == ADDR_IN_LIM_CTRL) begin
      return {s.opt_force, s.det_force, s.opt_en, s.in_lim};
    end else if (a == ADDR_PRE_TERM) begin
      return {s.prechg, s.term};
    end else if (a == ADDR_CHG_CTRL_ONE) begin
      return {s.term_en, s.ind_off, s.wd_sel, s.tmr_en, s.tmr_sel,
              s.tmr_half};
    end else if (a == ADDR_WD_KICK) begin
      return 8'(s.kick) << KICK_BIT;
    end
    return 8'h00;
  endfunction

  assign wr_lim = wr_en_i && (reg_addr_i == ADDR_IN_LIM_CTRL);
  assign wr_pt = wr_en_i && (reg_addr_i == ADDR_PRE_TERM);
  assign wr_ctl = wr_en_i && (reg_addr_i == ADDR_CHG_CTRL_ONE);
  assign wr_kick = wr_en_i && (reg_addr_i == ADDR_WD_KICK) &&
                   wr_data_i[KICK_BIT];
  assign charger_control_one_now = rd_mux(st_r, ADDR_CHG_CTRL_ONE);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    wd_fire = 1'b0;
    slowed = 1'b0;
    st_tick = 1'b0;
    if (optimizer_started_i) begin
      st_nxt.opt_force = 1'b0;
    end
    if (detect_done_i) begin
      st_nxt.det_force = 1'b0;
    end
    if (wr_lim) begin
      if (wr_data_i[OPT_FORCE_BIT] && st_r.opt_en) begin
        st_nxt.opt_force = 1'b1;
      end
      st_nxt.det_force = wr_data_i[DET_FORCE_BIT];
      st_nxt.opt_en = wr_data_i[OPT_EN_BIT];
      st_nxt.in_lim = wr_data_i[IN_LIM_LSB +: 5];
    end
    if (wr_pt) begin
      st_nxt.prechg = wr_data_i[PRE_LSB +: 4];
      st_nxt.term = wr_data_i[TERM_LSB +: 4];
    end
    if (wr_ctl) begin
      st_nxt = put_ctl(st_nxt, wr_data_i);
    end
    st_nxt.kick = wr_kick;

    if (st_r.kick || (wd_seconds(st_r.wd_sel) == 8'h00)) begin
      st_nxt.wd_pre = 32'h0;
      st_nxt.wd_sec = 8'h00;
    end else if (st_r.wd_pre == 32'(WD_TICK_CYCLES - 1)) begin
      st_nxt.wd_pre = 32'h0;
      // >= so a shortened period still fires
      if (st_r.wd_sec >= wd_seconds(st_r.wd_sel) - 8'h01) begin
        wd_fire = 1'b1;
        st_nxt.wd_sec = 8'h00;
      end else begin
        st_nxt.wd_sec = st_r.wd_sec + 8'h01;
      end
    end else begin
      st_nxt.wd_pre = st_r.wd_pre + 32'h1;
    end
    st_nxt.wd_exp = wd_fire;

    slowed = st_r.tmr_half && (input_regulation_i || thermal_regulation_i);
    if (!st_r.tmr_en || !charge_active_i) begin
      st_nxt.st_pre = 32'h0;
      st_nxt.st_min = 11'h000;
      st_nxt.st_phase = 1'b0;
      st_nxt.st_exp = 1'b0;
    end else if (!st_r.st_exp) begin
      if (st_r.st_pre == 32'(ST_TICK_CYCLES - 1)) begin
        st_nxt.st_pre = 32'h0;
        st_nxt.st_phase = slowed ? !st_r.st_phase : 1'b0;
        if (!slowed || st_r.st_phase) begin
          st_tick = 1'b1;
          st_nxt.st_min = st_r.st_min + 11'h001;
          if (st_r.st_min >= st_minutes(st_r.tmr_sel) - 11'h001) begin
            st_nxt.st_exp = 1'b1;
          end
        end
      end else begin
        st_nxt.st_pre = st_r.st_pre + 32'h1;
      end
    end

    if (wd_fire) begin
      st_nxt.opt_force = RESET_STATE.opt_force;
      st_nxt.det_force = RESET_STATE.det_force;
      st_nxt.prechg = RESET_STATE.prechg;
      st_nxt.term = RESET_STATE.term;
      st_nxt = put_ctl(st_nxt, RST_CHG_CTRL_ONE);
    end
    if (reg_reset_i) begin
      st_nxt.opt_force = RESET_STATE.opt_force;
      st_nxt.det_force = RESET_STATE.det_force;
      st_nxt.opt_en = RESET_STATE.opt_en;
      st_nxt.in_lim = RESET_STATE.in_lim;
      st_nxt.prechg = RESET_STATE.prechg;
      st_nxt.term = RESET_STATE.term;
      st_nxt = put_ctl(st_nxt, RST_CHG_CTRL_ONE);
      st_nxt.kick = 1'b0;
    end

    // codes above 1Ch act as 1Ch
    st_nxt.lim_eff = min2(min2(st_r.in_lim, IN_LIM_MAX_CODE),
                          min2(current_limit_pin_i, power_select_limit_i));
    if (st_r.opt_en) begin
      st_nxt.lim_eff = min2(st_nxt.lim_eff, optimizer_current_result_i);
    end
    // read data held until next read
    if (rd_en_i) begin
      st_nxt.rd_data = rd_mux(st_r, reg_addr_i);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_o = st_r.rd_data;
  assign force_optimizer_start_o = st_r.opt_force;
  assign force_input_source_detect_o = st_r.det_force;
  assign optimizer_enable_o = st_r.opt_en;
  assign input_current_limit_o = st_r.lim_eff;
  assign precharge_current_o = st_r.prechg;
  assign termination_current_o = st_r.term;
  assign termination_enable_o = st_r.term_en;
  assign charge_indicator_disable_o = st_r.ind_off;
  assign watchdog_expired_o = st_r.wd_exp;
  assign safety_timer_expired_o = st_r.st_exp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  opt_gate_a: assert property (
    wr_lim && wr_data_i[OPT_FORCE_BIT] && !st_r.opt_en && !st_r.opt_force
    |=> !force_optimizer_start_o) else $error("force set while disabled");
  opt_clear_a: assert property (
    optimizer_started_i && !(wr_lim && wr_data_i[OPT_FORCE_BIT])
    |=> !force_optimizer_start_o) else $error("force not cleared");
  det_set_a: assert property (
    wr_lim && wr_data_i[DET_FORCE_BIT] && !reg_reset_i && !wd_fire
    |=> force_input_source_detect_o) else $error("detect not set");
  lim_clamp_a: assert property (
    input_current_limit_o <= IN_LIM_MAX_CODE) else $error("limit over max");
  lim_min_a: assert property (
    1'b1 |=> (input_current_limit_o <= $past(current_limit_pin_i)) &&
    (input_current_limit_o <= $past(power_select_limit_i)))
    else $error("limit above a source");
  rst_dflt_a: assert property (
    reg_reset_i |=> termination_current_o == RST_PRE_TERM[TERM_LSB +: 4] &&
    precharge_current_o == RST_PRE_TERM[PRE_LSB +: 4] &&
    charger_control_one_now == RST_CHG_CTRL_ONE && optimizer_enable_o)
    else $error("defaults not restored");
  wd_keep_a: assert property (
    wd_fire && !reg_reset_i && !wr_en_i |=> watchdog_expired_o &&
    optimizer_enable_o == $past(st_r.opt_en) &&
    st_r.in_lim == $past(st_r.in_lim) && charger_control_one_now == RST_CHG_CTRL_ONE)
    else $error("watchdog expiry wrong");
  kick_clr_a: assert property (
    st_r.kick && !wr_kick && !reg_reset_i |=> !st_r.kick &&
    st_r.wd_sec == 8'h00) else $error("kick not cleared");
  wd_off_a: assert property (
    st_r.wd_sel == 2'b00 |=> st_r.wd_sec == 8'h00 && !watchdog_expired_o)
    else $error("watchdog ran while off");
  half_rate_a: assert property (
    slowed && st_r.tmr_en && charge_active_i && !st_r.st_exp &&
    !st_r.st_phase && st_r.st_pre == 32'(ST_TICK_CYCLES - 1)
    |=> $stable(st_r.st_min)) else $error("timer not slowed");
  tmr_off_a: assert property (
    !st_r.tmr_en |=> st_r.st_min == 11'h000 && !safety_timer_expired_o)
    else $error("timer ran while off");
  readback_a: assert property (
    rd_en_i && reg_addr_i == ADDR_CHG_CTRL_ONE
    |=> rd_data_o == $past(charger_control_one_now)) else $error("bad readback");

  opt_force_c: cover property (wr_lim && wr_data_i[OPT_FORCE_BIT] &&
                               st_r.opt_en ##1 force_optimizer_start_o);
  wd_fire_c: cover property (watchdog_expired_o);
  st_exp_c: cover property ($rose(safety_timer_expired_o));
  slowed_c: cover property (slowed && st_tick);
endmodule // clt_config_regs
`default_nettype wire

/* File: clt_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module clt_host_model (
  input wire logic clock_i,
  input wire logic [7:0] rd_data_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] wr_data_o,
  output logic wr_en_o,
  output logic rd_en_o
);
  initial begin
    reg_addr_o = 8'h00;
    wr_data_o = 8'h00;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
  end
  // released lines show the inverse so a stale byte never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    wr_data_o = d;
    wr_en_o = 1'b1;
    @(negedge clock_i);
    wr_en_o = 1'b0;
    reg_addr_o = ~a;
    wr_data_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    rd_en_o = 1'b1;
    @(negedge clock_i);
    rd_en_o = 1'b0;
    reg_addr_o = ~a;
    d = rd_data_i;
  endtask
  task automatic kick();
    wr(8'h07, 8'h40);
  endtask
endmodule // clt_host_model
`default_nettype wire

/* File: tb_clt_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_clt_config_regs;
  import clt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rreg = 1'b0;
  logic started = 1'b0;
  logic done = 1'b0;
  logic in_reg = 1'b0;
  logic th_reg = 1'b0;
  logic chg = 1'b0;
  logic [4:0] opt_res = 5'h1f;
  logic [4:0] pin_lim = 5'h1f;
  logic [4:0] psel = 5'h1f;
  logic [7:0] addr, wdat, rdat;
  logic wen, ren, f_opt, f_det, opt_en, t_en, i_dis, wd_exp, st_exp;
  logic [4:0] lim;
  logic [3:0] pre, term;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  clt_host_model host_u (
    .clock_i(clk), .rd_data_i(rdat), .reg_addr_o(addr),
    .wr_data_o(wdat), .wr_en_o(wen), .rd_en_o(ren));
  // short ticks keep hour-long timers within the run
  clt_config_regs #(.WD_TICK_CYCLES(4), .ST_TICK_CYCLES(2)) dut_u (
    .clock_i(clk), .rst_i(rst), .reg_addr_i(addr), .wr_data_i(wdat),
    .wr_en_i(wen), .rd_en_i(ren), .rd_data_o(rdat),
    .reg_reset_i(rreg), .optimizer_started_i(started),
    .detect_done_i(done), .optimizer_current_result_i(opt_res),
    .current_limit_pin_i(pin_lim), .power_select_limit_i(psel),
    .input_regulation_i(in_reg), .thermal_regulation_i(th_reg),
    .charge_active_i(chg), .force_optimizer_start_o(f_opt),
    .force_input_source_detect_o(f_det), .optimizer_enable_o(opt_en),
    .input_current_limit_o(lim), .precharge_current_o(pre),
    .termination_current_o(term), .termination_enable_o(t_en),
    .charge_indicator_disable_o(i_dis), .watchdog_expired_o(wd_exp),
    .safety_timer_expired_o(st_exp));
  always #25 clk = ~clk;
  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    check("readback", d, e);
  endtask
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask
  // e of zero means the event must not come within lim cycles
  task automatic measure(input bit st, input int e, input int lim);
    int n;
    n = 0;
    while (n < lim && (st ? st_exp : wd_exp) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    check("period", 8'((e > 0) ? (n >= e - 6) : (n == lim)), 8'h01);
  endtask
  task automatic t_reset();
    check("limit", {3'h0, lim}, 8'h19);
    check("flags", {t_en, i_dis, opt_en, f_opt, f_det}, 8'h14);
    chk_rd(8'h03, 8'h39);
    chk_rd(8'h04, 8'h22);
    chk_rd(8'h05, 8'h9d);
    chk_rd(8'h07, 8'h00);
    chk_rd(8'h10, 8'h00);
    host_u.wr(8'h05, 8'h4d);
    settle();
    check("flags", {t_en, i_dis}, 8'h01);
    chk_rd(8'h05, 8'h4d);
    host_u.wr(8'h04, 8'ha5);
    settle();
    check("pre_term", {pre, term}, 8'ha5);
  endtask
  task automatic t_limit();
    host_u.wr(8'h03, 8'h3f);
    settle();
    check("limit", {3'h0, lim}, 8'h1c);
    pin_lim = 5'h10;
    settle();
    check("limit", {3'h0, lim}, 8'h10);
    opt_res = 5'h08;
    settle();
    check("limit", {3'h0, lim}, 8'h08);
    psel = 5'h04;
    settle();
    check("limit", {3'h0, lim}, 8'h04);
    psel = 5'h1f;
    host_u.wr(8'h03, 8'h1f);
    settle();
    check("limit", {3'h0, lim}, 8'h10);
    pin_lim = 5'h1f;
    opt_res = 5'h1f;
  endtask
  task automatic t_force();
    host_u.wr(8'h03, 8'h80);
    settle();
    check("force_opt", {7'h0, f_opt}, 8'h00);
    host_u.wr(8'h03, 8'h20);
    host_u.wr(8'h03, 8'ha0);
    settle();
    check("force_opt", {7'h0, f_opt}, 8'h01);
    started = 1'b1;
    @(negedge clk);
    started = 1'b0;
    chk_rd(8'h03, 8'h20);
    host_u.wr(8'h03, 8'h60);
    settle();
    check("force_det", {7'h0, f_det}, 8'h01);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    settle();
    check("force_det", {7'h0, f_det}, 8'h00);
  endtask
  task automatic t_wdog();
    int e;
    host_u.wr(8'h03, 8'h3a);
    for (int s = 0; s < 4; s++) begin
      e = (s == 0) ? 0 : (40 << (s - 1)) * 4;
      host_u.wr(8'h05, 8'h8d | 8'(s << 4));
      host_u.kick();
      if (s == 1) begin
        host_u.wr(8'h04, 8'ha5);
        measure(1'b0, 0, 120);
        host_u.kick();
      end
      measure(1'b0, e, (s == 0) ? 700 : e + 6);
      if (s == 0) begin
        chk_rd(8'h07, 8'h00);
      end
      if (s == 1) begin
        chk_rd(8'h04, 8'h22);
        chk_rd(8'h03, 8'h3a);
        chk_rd(8'h05, 8'h9d);
      end
    end
  endtask
  task automatic t_safety();
    logic [7:0] v[8] = '{8'h88, 8'h8a, 8'h8c, 8'h8e, 8'h89, 8'h89,
      8'h88, 8'h80};
    int e[8] = '{600, 960, 1440, 2400, 1200, 1200, 600, 0};
    logic [7:0] ir = 8'b0001_0000;
    logic [7:0] tr = 8'b0110_0000;
    for (int i = 0; i < 8; i++) begin
      host_u.wr(8'h05, v[i]);
      in_reg = ir[i];
      th_reg = tr[i];
      chg = 1'b1;
      measure(1'b1, e[i], (e[i] > 0) ? e[i] + 6 : 700);
      chg = 1'b0;
      settle();
      check("st_clear", {7'h0, st_exp}, 8'h00);
    end
  endtask
  task automatic t_regreset();
    host_u.wr(8'h04, 8'ha5);
    rreg = 1'b1;
    @(negedge clk);
    rreg = 1'b0;
    chk_rd(8'h03, 8'h39);
    chk_rd(8'h04, 8'h22);
    chk_rd(8'h05, 8'h9d);
    check("limit", {3'h0, lim}, 8'h19);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_limit();
    t_force();
    t_wdog();
    t_safety();
    t_regreset();
    report_and_stop();
  end
endmodule // tb_clt_config_regs
`default_nettype wire
